// ### lvr_lut.sv
`timescale 1ns/10ps
module lvr_lut
    import lvr_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // host strobes
    input wire logic rd_idx_wr_in,
    input wire logic wr_idx_wr_in,
    input wire logic data_wr_in,
    input wire logic data_rd_in,
    input wire logic [7:0] wdata_in,
    input wire logic green_only_in,
    // host read values
    output logic [5:0] rd_value_out,
    output logic [7:0] wr_index_out,
    output logic [1:0] status_out,
    // display lookup
    input wire logic [7:0] pix_addr_in,
    output logic [5:0] gray_level_out
);
    typedef struct packed {
        logic [LUT_DEPTH-1:0][5:0] mem;
        logic [7:0] wr_idx;
        logic [7:0] rd_idx;
        logic [1:0] wr_ph;
        logic [1:0] rd_ph;
        logic [5:0] red;
        logic [5:0] grn;
        logic [1:0] status;
        logic [5:0] gray;
    } lvr_lut_st_t;

    lvr_lut_st_t s;
    lvr_lut_st_t next_s;
    logic [10:0] ntsc;
    logic [5:0] ntsc_gs;

    assign ntsc = NTSC_G * {5'h00, s.grn} + NTSC_R * {5'h00, s.red}
        + NTSC_B * {5'h00, wdata_in[5:0]};
    assign ntsc_gs = ntsc[10:5];

    always_comb begin
        next_s = s;
        next_s.gray = s.mem[pix_addr_in];
        if (wr_idx_wr_in) begin
            next_s.wr_idx = wdata_in;
            next_s.wr_ph = LUT_PH_FIRST;
            next_s.status = LUT_STAT_WRITE;
        end else if (data_wr_in) begin
            unique case (s.wr_ph)
                LUT_PH_FIRST: begin
                    next_s.red = wdata_in[5:0];
                    next_s.wr_ph = LUT_PH_SECOND;
                end
                LUT_PH_SECOND: begin
                    next_s.grn = wdata_in[5:0];
                    next_s.wr_ph = LUT_PH_LAST;
                end
                default: begin
                    // green-only drops red and blue; otherwise weight all three
                    next_s.mem[s.wr_idx] = green_only_in ? s.grn : ntsc_gs;
                    next_s.wr_idx = s.wr_idx + 8'h01;
                    next_s.wr_ph = LUT_PH_FIRST;
                end
            endcase
        end
        if (rd_idx_wr_in) begin
            next_s.rd_idx = wdata_in;
            next_s.rd_ph = LUT_PH_FIRST;
            next_s.status = LUT_STAT_READ;
        end else if (data_rd_in) begin
            if (s.rd_ph == LUT_PH_LAST) begin
                next_s.rd_idx = s.rd_idx + 8'h01;
                next_s.rd_ph = LUT_PH_FIRST;
            end else begin
                next_s.rd_ph = s.rd_ph + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // every one of the three reads gives the stored level
    assign rd_value_out = s.mem[s.rd_idx];
    assign wr_index_out = s.wr_idx;
    assign status_out = s.status;
    assign gray_level_out = s.gray;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_entry_write;
        data_wr_in && !wr_idx_wr_in && s.wr_ph == LUT_PH_LAST;
    endsequence

    sequence s_green_entry;
        s_entry_write ##0 green_only_in && s.wr_idx == s.rd_idx && !rd_idx_wr_in;
    endsequence

    a_green_store: assert property (
        s_entry_write ##0 green_only_in |=> s.mem[$past(s.wr_idx)] == $past(s.grn))
        else $error("green-only entry not stored from second write");

    a_ntsc_store: assert property (
        s_entry_write ##0 !green_only_in |=> s.mem[$past(s.wr_idx)] == $past(ntsc_gs))
        else $error("weighted entry not stored");

    a_read_green: assert property (
        s_green_entry ##1 (data_rd_in && !data_wr_in && !wr_idx_wr_in)
        |-> rd_value_out == $past(s.grn))
        else $error("green-only read does not return stored green");

    a_wr_advance: assert property (
        s_entry_write |=> s.wr_idx == $past(s.wr_idx) + 8'h01 && s.wr_ph == LUT_PH_FIRST)
        else $error("write index did not advance after third write");

    a_wr_hold: assert property (
        data_wr_in && !wr_idx_wr_in && s.wr_ph != LUT_PH_LAST |=> $stable(s.wr_idx))
        else $error("write index moved before third write");

    a_rd_advance: assert property (
        data_rd_in && !rd_idx_wr_in && s.rd_ph == LUT_PH_LAST
        |=> s.rd_idx == $past(s.rd_idx) + 8'h01)
        else $error("read index did not advance after third read");
endmodule : lvr_lut

// ### lvr_pkg.sv
// Contract
// - green-only mode ignores first and third data writes; second write's green is stored.
// - green-only mode returns the stored six-bit value on each of three reads.
// - lcd mode panel timing comes only from horizontal and vertical panel sizes.
// - lcd mode timing parameters besides panel sizes are fixed hardware constants.
// - lcd mode ignores timing of indices 00h, 02h-06h, 10h, 15h, 16h; code fixes only bits 4-0 of 03h.
// - lcd mode ignores timing of selected bits in indices 07h, 09h, 11h.
// - ignored timing registers and bits stay writable and readable with no effect.
// - indices 01h and 12h keep full function in lcd and crt modes.
// - crt mode uses the complete display-timing register set.
// - non-timing display registers behave as standard in every mode.
// - removed legacy bits keep storage positions but have no effect.
// - aux 01h bit 4 selects green-only or ntsc weighting when entries are written.
// - write and read lookup indices advance after each group of three accesses.
// - aux 0Bh bits 1,0 equal to 01 selects lcd-only display.
// - lcd-only with aux 00h bit 0 set maps indices 01h, 12h to panel sizes.
package lvr_pkg;
    // host port addresses
    localparam logic [9:0] ADDR_LUT_RD_IDX = 10'h3C7;
    localparam logic [9:0] ADDR_LUT_WR_IDX = 10'h3C8;
    localparam logic [9:0] ADDR_LUT_DATA = 10'h3C9;
    localparam logic [9:0] ADDR_CRTC_IDX = 10'h3D4;
    localparam logic [9:0] ADDR_CRTC_DATA = 10'h3D5;
    localparam logic [9:0] ADDR_AUX_IDX = 10'h3DE;
    localparam logic [9:0] ADDR_AUX_DATA = 10'h3DF;

    // display-timing register indices
    localparam int CRTC_NUM = 25;
    localparam logic [7:0] CRTC_LAST = 8'h18;
    localparam logic [7:0] IDX_HDE_END = 8'h01;
    localparam logic [7:0] IDX_VDE_END = 8'h12;
    localparam logic [4:0] IDX_HTOTAL = 5'h00;
    localparam logic [4:0] IDX_HDE = 5'h01;
    localparam logic [4:0] IDX_OVERFLOW = 5'h07;
    localparam logic [4:0] IDX_CUR_END = 5'h0B;
    localparam logic [4:0] IDX_START_HI = 5'h0C;
    localparam logic [4:0] IDX_VRS = 5'h10;
    localparam logic [4:0] IDX_VDE = 5'h12;

    // auxiliary registers
    localparam int AUX_NUM = 16;
    localparam logic [7:0] AUX_LAST = 8'h0F;
    localparam logic [3:0] AUX_PANEL = 4'h0;
    localparam logic [3:0] AUX_GRAY = 4'h1;
    localparam logic [3:0] AUX_TARGET = 4'hB;
    localparam int BIT_PANEL_SEL = 0;
    localparam int BIT_GREEN_ONLY = 4;
    localparam logic [1:0] TARGET_LCD_ONLY = 2'h1;

    // gray lookup table
    localparam int LUT_DEPTH = 256;
    localparam logic [1:0] LUT_PH_FIRST = 2'h0;
    localparam logic [1:0] LUT_PH_SECOND = 2'h1;
    localparam logic [1:0] LUT_PH_LAST = 2'h2;
    localparam logic [1:0] LUT_STAT_WRITE = 2'h0;
    localparam logic [1:0] LUT_STAT_READ = 2'h3;
    localparam logic [10:0] NTSC_G = 11'h013;
    localparam logic [10:0] NTSC_R = 11'h009;
    localparam logic [10:0] NTSC_B = 11'h004;

    typedef logic [CRTC_NUM-1:0][7:0] lvr_crtc_t;

    // bits whose timing role is dropped in lcd-only mode, index 18h first
    localparam lvr_crtc_t LCD_MASK = {
        8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h0F, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 8'hED,
        8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h00, 8'hFF};
    // legacy bits that store but never act
    localparam lvr_crtc_t LEGACY_MASK = {
        8'h00, 8'h0C, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h40, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h00};
    localparam lvr_crtc_t LCD_FIXED_RST = {
        8'h00, 8'h00, 8'h04, 8'hE7, 8'h00, 8'h00, 8'h00, 8'h0C, 8'hEA,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h2C,
        8'h0B, 8'h80, 8'h54, 8'h02, 8'h50, 8'h00, 8'h5F};
    localparam logic [7:0] H_PANEL_RST = 8'h4F;
    localparam logic [7:0] V_PANEL_RST = 8'hDF;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lvr_req_t;

    typedef struct packed {
        logic lcd_mode;
        logic [7:0] h_panel;
        logic [7:0] v_panel;
        lvr_crtc_t crtc;
    } lvr_timing_t;
endpackage : lvr_pkg

// ### lvr_shim.sv
`timescale 1ns/10ps
module lvr_shim
    import lvr_pkg::*;
#(
    parameter lvr_crtc_t LCD_FIXED = LCD_FIXED_RST
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // register port
    input wire lvr_req_t req_in,
    output logic [7:0] rdata_out,
    // display lookup
    input wire logic [7:0] pix_addr_in,
    output logic [5:0] gray_level_out,
    // to the timing generator
    output lvr_timing_t timing_out
);
    typedef struct packed {
        lvr_crtc_t crtc;
        logic [7:0] crtc_idx;
        logic [AUX_NUM-1:0][7:0] aux;
        logic [7:0] aux_idx;
        logic [7:0] h_panel;
        logic [7:0] v_panel;
        logic [7:0] rdata;
        lvr_timing_t timing;
    } lvr_st_t;

    lvr_st_t s;
    lvr_st_t next_s;
    lvr_crtc_t eff;
    logic lcd;
    logic redir;
    logic [5:0] lut_value;
    logic [7:0] lut_wr_index;
    logic [1:0] lut_status;
    logic green_only;

    function automatic logic crtc_hit(input logic [7:0] idx);
        return idx <= CRTC_LAST;
    endfunction : crtc_hit

    // 2'b01 horizontal panel size, 2'b10 vertical, 2'b00 normal register
    function automatic logic [1:0] panel_sel(input logic [7:0] idx, input logic on);
        return {on && idx == IDX_VDE_END, on && idx == IDX_HDE_END};
    endfunction : panel_sel

    assign lcd = s.aux[AUX_TARGET][1:0] == TARGET_LCD_ONLY;
    assign redir = lcd && s.aux[AUX_PANEL][BIT_PANEL_SEL];
    assign green_only = s.aux[AUX_GRAY][BIT_GREEN_ONLY];

    lvr_lut u_lut (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .rd_idx_wr_in(req_in.wr && req_in.addr == ADDR_LUT_RD_IDX),
        .wr_idx_wr_in(req_in.wr && req_in.addr == ADDR_LUT_WR_IDX),
        .data_wr_in(req_in.wr && req_in.addr == ADDR_LUT_DATA),
        .data_rd_in(req_in.rd && req_in.addr == ADDR_LUT_DATA),
        .wdata_in(req_in.wdata),
        .green_only_in(green_only),
        .rd_value_out(lut_value),
        .wr_index_out(lut_wr_index),
        .status_out(lut_status),
        .pix_addr_in(pix_addr_in),
        .gray_level_out(gray_level_out)
    );

    // value each timing register presents to the generator
    for (genvar i = 0; i < CRTC_NUM; i++) begin : g_eff
        logic [7:0] merged;
        // lcd-only swaps dropped timing bits for fixed constants
        assign merged = lcd ? ((s.crtc[i] & ~LCD_MASK[i]) | (LCD_FIXED[i] & LCD_MASK[i]))
            : s.crtc[i];
        // legacy bits never reach the generator
        assign eff[i] = merged & ~LEGACY_MASK[i];
    end

    always_comb begin
        next_s = s;
        next_s.rdata = 8'h00;
        if (req_in.wr) begin
            unique case (req_in.addr)
                ADDR_CRTC_IDX: next_s.crtc_idx = req_in.wdata;
                ADDR_CRTC_DATA: begin
                    unique case (panel_sel(s.crtc_idx, redir))
                        2'h1: next_s.h_panel = req_in.wdata;
                        2'h2: next_s.v_panel = req_in.wdata;
                        default: begin
                            if (crtc_hit(s.crtc_idx)) begin
                                // every bit keeps plain storage
                                next_s.crtc[s.crtc_idx[4:0]] = req_in.wdata;
                            end
                        end
                    endcase
                end
                ADDR_AUX_IDX: next_s.aux_idx = req_in.wdata;
                ADDR_AUX_DATA: begin
                    if (s.aux_idx <= AUX_LAST) begin
                        next_s.aux[s.aux_idx[3:0]] = req_in.wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        if (req_in.rd) begin
            unique case (req_in.addr)
                ADDR_LUT_RD_IDX: next_s.rdata = {6'h00, lut_status};
                ADDR_LUT_WR_IDX: next_s.rdata = lut_wr_index;
                ADDR_LUT_DATA: next_s.rdata = {2'h0, lut_value};
                ADDR_CRTC_IDX: next_s.rdata = s.crtc_idx;
                ADDR_CRTC_DATA: begin
                    unique case (panel_sel(s.crtc_idx, redir))
                        2'h1: next_s.rdata = s.h_panel;
                        2'h2: next_s.rdata = s.v_panel;
                        default: begin
                            if (crtc_hit(s.crtc_idx)) begin
                                next_s.rdata = s.crtc[s.crtc_idx[4:0]];
                            end
                        end
                    endcase
                end
                ADDR_AUX_IDX: next_s.rdata = s.aux_idx;
                ADDR_AUX_DATA: begin
                    if (s.aux_idx <= AUX_LAST) begin
                        next_s.rdata = s.aux[s.aux_idx[3:0]];
                    end
                end
                default: begin
                end
            endcase
        end
        next_s.timing.lcd_mode = lcd;
        next_s.timing.h_panel = s.h_panel;
        next_s.timing.v_panel = s.v_panel;
        next_s.timing.crtc = eff;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            s <= '0;
            s.h_panel <= H_PANEL_RST;
            s.v_panel <= V_PANEL_RST;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_out = s.rdata;
    assign timing_out = s.timing;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_dummy_wr;
        req_in.wr && req_in.addr == ADDR_CRTC_DATA && s.crtc_idx == 8'h00;
    endsequence

    sequence s_dummy_rd;
        req_in.rd && req_in.addr == ADDR_CRTC_DATA && s.crtc_idx == 8'h00;
    endsequence

    a_lcd_fixed: assert property (
        lcd |=> s.timing.crtc[IDX_HTOTAL] == LCD_FIXED[IDX_HTOTAL]
            && s.timing.crtc[IDX_VRS] == LCD_FIXED[IDX_VRS])
        else $error("lcd timing not taken from fixed constants");

    a_lcd_bits: assert property (
        lcd |=> (s.timing.crtc[IDX_OVERFLOW] & LCD_MASK[IDX_OVERFLOW])
            == (LCD_FIXED[IDX_OVERFLOW] & LCD_MASK[IDX_OVERFLOW])
            && (s.timing.crtc[IDX_OVERFLOW] & ~LCD_MASK[IDX_OVERFLOW])
            == ($past(s.crtc[IDX_OVERFLOW]) & ~LCD_MASK[IDX_OVERFLOW]))
        else $error("overflow bits not split in lcd mode");

    a_crt_pass: assert property (
        !lcd |=> s.timing.crtc[IDX_HTOTAL] == $past(s.crtc[IDX_HTOTAL])
            && s.timing.crtc[IDX_VRS] == $past(s.crtc[IDX_VRS]))
        else $error("crt timing does not follow registers");

    a_de_end_full: assert property (
        1'b1 |=> s.timing.crtc[IDX_HDE] == $past(s.crtc[IDX_HDE])
            && s.timing.crtc[IDX_VDE] == $past(s.crtc[IDX_VDE]))
        else $error("display enable end lost its function");

    a_non_timing: assert property (
        1'b1 |=> s.timing.crtc[IDX_START_HI] == $past(s.crtc[IDX_START_HI]))
        else $error("non-timing register altered");

    a_legacy_zero: assert property (
        req_in.wr && req_in.addr == ADDR_CRTC_DATA && s.crtc_idx == {3'h0, IDX_CUR_END}
        |=> ##1 (s.timing.crtc[IDX_CUR_END] & LEGACY_MASK[IDX_CUR_END]) == 8'h00
            && s.crtc[IDX_CUR_END] == $past(req_in.wdata, 2))
        else $error("legacy bits reached the generator or were not stored");

    a_dummy_rb: assert property (
        s_dummy_wr ##1 s_dummy_rd |=> rdata_out == $past(req_in.wdata, 2))
        else $error("dummy register did not read back");

    a_panel_redirect: assert property (
        req_in.wr && req_in.addr == ADDR_CRTC_DATA && redir && s.crtc_idx == IDX_HDE_END
        |=> s.h_panel == $past(req_in.wdata) && $stable(s.crtc[IDX_HDE]))
        else $error("panel size write not redirected");

    sequence s_crtc_wr;
        req_in.wr && req_in.addr == ADDR_CRTC_DATA;
    endsequence

    sequence s_crtc_rd;
        req_in.rd && req_in.addr == ADDR_CRTC_DATA;
    endsequence

    a_vpanel_redirect: assert property (
        s_crtc_wr ##0 redir && s.crtc_idx == IDX_VDE_END
        |=> s.v_panel == $past(req_in.wdata) && $stable(s.crtc[IDX_VDE]))
        else $error("v panel write not redirected");

    a_hpanel_read: assert property (
        s_crtc_rd ##0 redir && s.crtc_idx == IDX_HDE_END
        |=> rdata_out == $past(s.h_panel))
        else $error("h panel read not redirected");

    a_vpanel_read: assert property (
        s_crtc_rd ##0 redir && s.crtc_idx == IDX_VDE_END
        |=> rdata_out == $past(s.v_panel))
        else $error("v panel read not redirected");

    a_de_end_store: assert property (
        s_crtc_wr ##0 !redir && s.crtc_idx == IDX_HDE_END
        |=> s.crtc[IDX_HDE] == $past(req_in.wdata) && $stable(s.h_panel))
        else $error("display enable end write lost");

    a_reg_store: assert property (
        s_crtc_wr ##0 panel_sel(s.crtc_idx, redir) == 2'h0 && crtc_hit(s.crtc_idx)
        |=> s.crtc[$past(s.crtc_idx[4:0])] == $past(req_in.wdata))
        else $error("timing register write not stored");

    a_reg_read: assert property (
        s_crtc_rd ##0 panel_sel(s.crtc_idx, redir) == 2'h0 && crtc_hit(s.crtc_idx)
        |=> rdata_out == $past(s.crtc[s.crtc_idx[4:0]]))
        else $error("timing register read back wrong");

    a_range_wr: assert property (
        s_crtc_wr ##0 !crtc_hit(s.crtc_idx) |=> $stable(s.crtc))
        else $error("write beyond last index stored");

    a_range_rd: assert property (
        s_crtc_rd ##0 !crtc_hit(s.crtc_idx) |=> rdata_out == 8'h00)
        else $error("read beyond last index not zero");

    a_rdata_idle: assert property (
        !req_in.rd |=> rdata_out == 8'h00)
        else $error("read data without a read");

    a_aux_store: assert property (
        req_in.wr && req_in.addr == ADDR_AUX_DATA && s.aux_idx <= AUX_LAST
        |=> s.aux[$past(s.aux_idx[3:0])] == $past(req_in.wdata))
        else $error("aux write not stored");

    a_aux_read: assert property (
        req_in.rd && req_in.addr == ADDR_AUX_DATA && s.aux_idx <= AUX_LAST
        |=> rdata_out == $past(s.aux[s.aux_idx[3:0]]))
        else $error("aux read back wrong");

    a_aux_range: assert property (
        req_in.rd && req_in.addr == ADDR_AUX_DATA && s.aux_idx > AUX_LAST |=> rdata_out == 8'h00)
        else $error("aux read beyond last index not zero");

    a_wr_index_read: assert property (
        req_in.rd && req_in.addr == ADDR_LUT_WR_IDX |=> rdata_out == $past(lut_wr_index))
        else $error("write index read back wrong");

    a_lcd_flag: assert property (
        !rst_in
        |=> timing_out.lcd_mode == ($past(s.aux[AUX_TARGET][1:0]) == TARGET_LCD_ONLY))
        else $error("lcd flag does not follow target");

    a_panel_copy: assert property (
        !rst_in |=> timing_out.h_panel == $past(s.h_panel)
            && timing_out.v_panel == $past(s.v_panel))
        else $error("panel sizes not passed on");

    a_lcd_all_fixed: assert property (
        lcd |=> (timing_out.crtc & LCD_MASK) == (LCD_FIXED & LCD_MASK & ~LEGACY_MASK))
        else $error("lcd timing bits not fixed");

    a_lcd_keep: assert property (
        lcd |=> (timing_out.crtc & ~LCD_MASK) == ($past(s.crtc) & ~LCD_MASK & ~LEGACY_MASK))
        else $error("lcd kept bits do not follow registers");

    a_crt_all: assert property (
        !lcd |=> timing_out.crtc == ($past(s.crtc) & ~LEGACY_MASK))
        else $error("crt timing set differs from registers");

    a_legacy_all: assert property (
        !rst_in |=> (timing_out.crtc & LEGACY_MASK) == '0)
        else $error("legacy bits seen by the generator");

    a_idx_store: assert property (
        req_in.wr && req_in.addr == ADDR_CRTC_IDX |=> s.crtc_idx == $past(req_in.wdata))
        else $error("timing index not stored");
endmodule : lvr_shim

// ### tb_lvr_shim.sv
`timescale 1ns/10ps
module tb_lvr_shim;
    import lvr_pkg::*;

    logic mclk_in;
    logic rst_in;
    lvr_req_t req;
    logic [7:0] rdata;
    logic [7:0] pix;
    logic [5:0] gray;
    lvr_timing_t tim;
    int n_mismatch;
    int cmp_count;

    lvr_shim #(
        .LCD_FIXED(LCD_FIXED_RST)
    ) u_dut (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .req_in(req),
        .rdata_out(rdata),
        .pix_addr_in(pix),
        .gray_level_out(gray),
        .timing_out(tim)
    );

    initial mclk_in = 1'b0;
    always #20 mclk_in = ~mclk_in;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // each access holds its strobe for one edge, then one idle edge
    task automatic bus_wr(input logic [9:0] addr, input logic [7:0] data);
        req.addr <= addr;
        req.wdata <= data;
        req.wr <= 1'b1;
        @(posedge mclk_in);
        req.wr <= 1'b0;
        @(posedge mclk_in);
    endtask : bus_wr

    task automatic bus_rd(input logic [9:0] addr, input logic [7:0] exp);
        req.addr <= addr;
        req.rd <= 1'b1;
        @(posedge mclk_in);
        req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge mclk_in);
    endtask : bus_rd

    // write, then read in the very next cycle with no gap between strobes
    task automatic wr_rd(input logic [9:0] addr, input logic [7:0] data, input logic [7:0] exp);
        req.addr <= addr;
        req.wdata <= data;
        req.wr <= 1'b1;
        @(posedge mclk_in);
        req.wr <= 1'b0;
        req.rd <= 1'b1;
        @(posedge mclk_in);
        req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge mclk_in);
    endtask : wr_rd

    task automatic crtc_wr(input logic [7:0] idx, input logic [7:0] data);
        bus_wr(ADDR_CRTC_IDX, idx);
        bus_wr(ADDR_CRTC_DATA, data);
    endtask : crtc_wr

    task automatic crtc_rd(input logic [7:0] idx, input logic [7:0] exp);
        bus_wr(ADDR_CRTC_IDX, idx);
        bus_rd(ADDR_CRTC_DATA, exp);
    endtask : crtc_rd

    task automatic aux_wr(input logic [7:0] idx, input logic [7:0] data);
        bus_wr(ADDR_AUX_IDX, idx);
        bus_wr(ADDR_AUX_DATA, data);
        repeat (3) @(posedge mclk_in);
    endtask : aux_wr

    task automatic lut_wr(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
        bus_wr(ADDR_LUT_DATA, r);
        bus_wr(ADDR_LUT_DATA, g);
        bus_wr(ADDR_LUT_DATA, b);
    endtask : lut_wr

    task automatic gray_chk(input logic [7:0] addr, input logic [5:0] exp);
        pix <= addr;
        repeat (2) @(posedge mclk_in);
        #1;
        chk({2'h0, gray}, {2'h0, exp});
        @(posedge mclk_in);
    endtask : gray_chk

    function automatic logic [7:0] pat(input int i);
        return 8'(8'h5A + i * 8'h13);
    endfunction : pat

    function automatic logic [7:0] lcd_exp(input int i);
        logic [7:0] v;
        v = (pat(i) & ~LCD_MASK[i]) | (LCD_FIXED_RST[i] & LCD_MASK[i]);
        return v & ~LEGACY_MASK[i];
    endfunction : lcd_exp

    initial begin
        repeat (20000) @(posedge mclk_in);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        rst_in = 1'b1;
        req = '0;
        pix = 8'h00;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        chk(tim.h_panel, H_PANEL_RST);
        chk(tim.v_panel, V_PANEL_RST);
        chk({7'h00, tim.lcd_mode}, 8'h00);
        chk(rdata, 8'h00);
        @(posedge mclk_in);
        crtc_rd(8'h03, 8'h00);
        bus_rd(10'h3C0, 8'h00);
        $display("test reset done");

        // green-only entries at 05h and 06h, written back to back
        aux_wr(8'h01, 8'h10);
        bus_wr(ADDR_LUT_WR_IDX, 8'h05);
        lut_wr(8'h3F, 8'h2A, 8'h15);
        // entry 06h is read in the cycle right after its third write
        bus_wr(ADDR_LUT_RD_IDX, 8'h06);
        bus_wr(ADDR_LUT_DATA, 8'h11);
        bus_wr(ADDR_LUT_DATA, 8'h22);
        wr_rd(ADDR_LUT_DATA, 8'h33, 8'h22);
        bus_rd(ADDR_LUT_WR_IDX, 8'h07);
        bus_wr(ADDR_LUT_RD_IDX, 8'h05);
        bus_rd(ADDR_LUT_RD_IDX, 8'h03);
        repeat (3) bus_rd(ADDR_LUT_DATA, 8'h2A);
        repeat (3) bus_rd(ADDR_LUT_DATA, 8'h22);
        gray_chk(8'h05, 6'h2A);
        gray_chk(8'h06, 6'h22);
        $display("test green-only done");

        // weighted entry: (19*10h + 9*20h + 4*08h) / 32 = 13h
        aux_wr(8'h01, 8'h00);
        bus_wr(ADDR_LUT_WR_IDX, 8'h10);
        bus_rd(ADDR_LUT_RD_IDX, 8'h00);
        lut_wr(8'h20, 8'h10, 8'h08);
        gray_chk(8'h10, 6'h13);
        $display("test weighting select done");

        // crt mode: all timing registers act, legacy bits never do
        for (int i = 0; i < CRTC_NUM; i++) begin
            crtc_wr(8'(i), pat(i));
        end
        repeat (3) @(posedge mclk_in);
        for (int i = 0; i < CRTC_NUM; i++) begin
            chk(tim.crtc[i], pat(i) & ~LEGACY_MASK[i]);
            crtc_rd(8'(i), pat(i));
        end
        bus_wr(ADDR_CRTC_IDX, 8'h00);
        wr_rd(ADDR_CRTC_DATA, 8'hA5, 8'hA5);
        bus_wr(ADDR_CRTC_DATA, pat(0));
        bus_wr(ADDR_CRTC_IDX, 8'h19);
        bus_wr(ADDR_CRTC_DATA, 8'hFF);
        bus_rd(ADDR_CRTC_DATA, 8'h00);
        $display("test crt timing done");

        // lcd-only mode: ignored registers become fixed constants
        aux_wr(8'h0B, 8'h01);
        chk({7'h00, tim.lcd_mode}, 8'h01);
        for (int i = 0; i < CRTC_NUM; i++) begin
            chk(tim.crtc[i], lcd_exp(i));
            crtc_rd(8'(i), pat(i));
        end
        $display("test lcd timing done");

        // panel size redirect of indices 01h and 12h
        aux_wr(8'h00, 8'h01);
        crtc_wr(IDX_HDE_END, 8'h27);
        crtc_wr(IDX_VDE_END, 8'h1D);
        repeat (3) @(posedge mclk_in);
        chk(tim.h_panel, 8'h27);
        chk(tim.v_panel, 8'h1D);
        chk(tim.crtc[1], pat(1));
        chk(tim.crtc[18], pat(18));
        crtc_rd(IDX_HDE_END, 8'h27);
        crtc_rd(IDX_VDE_END, 8'h1D);
        aux_wr(8'h0B, 8'h00);
        chk({7'h00, tim.lcd_mode}, 8'h00);
        chk(tim.crtc[0], pat(0));
        crtc_rd(IDX_HDE_END, pat(1));
        crtc_rd(IDX_VDE_END, pat(18));
        $display("test panel redirect done");

        complete_run();
    end
endmodule : tb_lvr_shim
